/* File: src/sadc_defines.svh */
// Purpose: constants for the converter host port
// Assumes: 125 MHz clock, 8 ns period
// Notes: times are kept in ns, cycle counts derived from them
// Summary of operation
// - busy_n goes low when a conversion starts and stays low until the new result is stored.
// - half_select low shows the upper 8 result bits on both bus bytes, high shows the whole 16-bit result.
// - chip_select_n and read_convert_n are ORed, so a chip select fall with read_convert_n low starts a conversion.
// - the result bus is released whenever chip_select_n is high or read_convert_n is low.
// - the result's top bit sits on bus bit 15; with half_select high the whole result descends to bit 0.
// - results are 16-bit two's complement values.
// - with select low and busy_n high a read_convert_n fall starts a conversion; its rise enables the output.
// - a convert command while busy_n is low aborts the conversion and restarts the converter.
`ifndef SADC_DEFINES_SVH
`define SADC_DEFINES_SVH
`define SADC_CLK_PERIOD_NS 8
`define SADC_CONV_TIME_NS 3200
`define SADC_CONV_CYCLES ((`SADC_CONV_TIME_NS) / (`SADC_CLK_PERIOD_NS))
`define SADC_RESULT_W 16
`define SADC_HALF_W 8
`define SADC_FIFO_DEPTH 8
`endif

/* File: src/sadc_pkg.sv */
// Purpose: types for the converter host port
// Assumes: sadc_defines.svh included first
// Notes: types only
`include "sadc_defines.svh"
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_IDLE = 2'b00,
    SADC_CONV = 2'b01,
    SADC_DONE = 2'b10
  } sadc_state_t;

  typedef struct packed {
    logic chip_select_n;
    logic read_convert_n;
    logic half_select;
  } sadc_ctl_t;

  typedef struct packed {
    logic [`SADC_RESULT_W-1:0] data;
    logic oe;
  } sadc_bus_t;
endpackage : sadc_pkg

/* File: src/sadc_fifo.sv */
// Purpose: small sample fifo in the result path
// Assumes: single clock, synchronous inputs
// Notes: full and empty are exact; reads are registered-free
`timescale 1ns/1ps
module sadc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  // handshake terms; a full fifo stalls its filler
  always_comb begin
    in_ready = (cnt_q != (AW+1)'(DEPTH));
    out_valid = (cnt_q != '0);
    out_data = mem_q[rd_q];
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    wr_d = push ? bump(wr_q) : wr_q;
    rd_d = pop ? bump(rd_q) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage has no reset, saves area
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule : sadc_fifo

/* File: src/sadc_port.sv */
// Purpose: control and parallel result port of a sampling converter
// Assumes: host pins synchronous to clk; samples arrive from the converter core
// Notes: core samples are buffered; the port drains one per conversion
`timescale 1ns/1ps
`include "sadc_defines.svh"
module sadc_port
  import sadc_pkg::*;
#(
  parameter int CONV_CYCLES = `SADC_CONV_CYCLES
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic chip_select_n,
  input wire logic read_convert_n,
  input wire logic half_select,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [`SADC_RESULT_W-1:0] sample_data,
  output logic busy_n,
  output logic [`SADC_RESULT_W-1:0] result_bus_o,
  output logic [`SADC_RESULT_W-1:0] result_bus_oe
);
  localparam int CW = $clog2(CONV_CYCLES + 1);

  sadc_ctl_t ctl, ctl_q;
  sadc_state_t st_q, st_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [`SADC_RESULT_W-1:0] res_q, res_d;
  logic busy_n_q, busy_n_d;
  sadc_bus_t bus_q, bus_d;
  logic fifo_valid, fifo_pop, fifo_ready;
  logic [`SADC_RESULT_W-1:0] fifo_data;
  logic or_now, or_prev, start;

  assign ctl = '{chip_select_n: chip_select_n, read_convert_n: read_convert_n,
                 half_select: half_select};

  // core samples wait here; a stalled port back-pressures the core
  sadc_fifo #(
    .WIDTH(`SADC_RESULT_W),
    .DEPTH(`SADC_FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .arst_n(arst_n),
    .in_valid(sample_valid),
    .in_ready(fifo_ready),
    .in_data(sample_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  always_comb begin
    sample_ready = fifo_ready;
  end

  // start detect on the falling edge of the ORed lines, either line may fall last
  always_comb begin
    or_now = ctl.chip_select_n | ctl.read_convert_n;
    or_prev = ctl_q.chip_select_n | ctl_q.read_convert_n;
    start = or_prev && !or_now;
  end

  // conversion sequencer
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    res_d = res_q;
    busy_n_d = busy_n_q;
    fifo_pop = 1'b0;
    if (start) begin
      // a start while busy aborts and restarts the count
      st_d = SADC_CONV;
      cnt_d = CW'(CONV_CYCLES - 1);
      busy_n_d = 1'b0;
    end else begin
      case (st_q)
        SADC_IDLE: begin
          busy_n_d = 1'b1;
        end
        SADC_CONV: begin
          if (cnt_q != '0) begin
            cnt_d = cnt_q - 1'b1;
          end else if (fifo_valid) begin
            // result stored in the same edge that busy rises
            fifo_pop = 1'b1;
            res_d = fifo_data;
            st_d = SADC_DONE;
            busy_n_d = 1'b1;
          end
        end
        SADC_DONE: begin
          st_d = SADC_IDLE;
        end
        default: begin
          st_d = SADC_IDLE;
          busy_n_d = 1'b1;
        end
      endcase
    end
  end

  // bus drive: released when select high or read_convert low
  always_comb begin
    bus_d.oe = !chip_select_n && read_convert_n;
    if (!half_select) begin
      bus_d.data = {{`SADC_HALF_W{1'b0}}, res_d[`SADC_RESULT_W-1 -: `SADC_HALF_W]};
    end else begin
      bus_d.data = {{`SADC_HALF_W{1'b0}}, res_d[`SADC_HALF_W-1:0]};
    end
    // a full-width read keeps msb on bit 15 down to lsb on bit 0
    bus_d.data[`SADC_RESULT_W-1:`SADC_HALF_W] = res_d[`SADC_RESULT_W-1:`SADC_HALF_W];
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl_q <= '{chip_select_n: 1'b1, read_convert_n: 1'b1, half_select: 1'b0};
      st_q <= SADC_IDLE;
      cnt_q <= '0;
      res_q <= '0;
      busy_n_q <= 1'b1;
      bus_q <= '0;
    end else begin
      ctl_q <= ctl;
      st_q <= st_d;
      cnt_q <= cnt_d;
      res_q <= res_d;
      busy_n_q <= busy_n_d;
      bus_q <= bus_d;
    end
  end

  always_comb begin
    busy_n = busy_n_q;
    result_bus_o = bus_q.data;
    result_bus_oe = {`SADC_RESULT_W{bus_q.oe}};
  end
endmodule : sadc_port

/* File: test/sadc_port_monitor.sv */
// Purpose: port checker
// Assumes: CONV_CYCLES is 4
// Notes: pins only
`timescale 1ns/1ps
module sadc_port_monitor (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic chip_select_n,
  input wire logic read_convert_n,
  input wire logic half_select,
  input wire logic busy_n,
  input wire logic [15:0] result_bus_o,
  input wire logic [15:0] result_bus_oe
);
  logic idle_q;
  wire idle_d = chip_select_n | read_convert_n;
  wire go = idle_q & ~idle_d;
  wire rd = ~chip_select_n & read_convert_n;
  // last pin or, to find the start edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) idle_q <= 1'b1;
    else idle_q <= idle_d;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  conv_len_a: assert property (go |=> !busy_n[*4]) else $error("len");
  busy_why_a: assert property ($fell(busy_n) |-> $past(go)) else $error("fall");
  busy_min_a: assert property ($rose(busy_n) |-> !$past(busy_n, 4)) else $error("min");
  bus_off_a: assert property (!rd |=> result_bus_oe == 16'h0000) else $error("off");
  bus_on_a: assert property (rd |=> result_bus_oe == 16'hffff) else $error("on");
  go_hiz_a: assert property (go |=> result_bus_oe == 16'h0000) else $error("hiz");
  half_low_a: assert property (rd && !half_select |=>
    result_bus_o[7:0] == result_bus_o[15:8]) else $error("half");
  top_hold_a: assert property (rd && $past(rd) && busy_n && $past(busy_n) |=>
    $stable(result_bus_o[15:8])) else $error("top");
  cover property (go && !busy_n);
  cover property ($rose(busy_n));
  cover property (rd && half_select);
endmodule : sadc_port_monitor
bind sadc_port sadc_port_monitor mon (.clk(clk), .arst_n(arst_n), .chip_select_n(chip_select_n),
  .read_convert_n(read_convert_n), .half_select(half_select), .busy_n(busy_n),
  .result_bus_o(result_bus_o), .result_bus_oe(result_bus_oe));

/* File: test/sadc_host_model.sv */
// Purpose: host on the pins
// Assumes: pins move at falling edges
// Notes: cut re-falls while busy
`timescale 1ns/1ps
module sadc_host_model (
  input wire logic clk,
  input wire logic [15:0] bus,
  output logic cs_n,
  output logic rc_n,
  output logic hsel
);
  initial {cs_n, rc_n, hsel} = 3'b110;
  // both low for 40 ns, or 16 ns on a cut
  task automatic convert(input logic cut);
    @(negedge clk);
    {cs_n, rc_n} = 2'b00;
    repeat (cut ? 2 : 5) @(negedge clk);
    rc_n = 1'b1;
    @(negedge clk);
    {cs_n, rc_n} = cut ? 2'b00 : 2'b11;
    // a cut re-fall is let go again, so that the next command is a fresh fall
    if (cut) begin
      @(negedge clk);
      {cs_n, rc_n} = 2'b11;
    end
  endtask : convert
  // byte picked before the read opens
  task automatic read(input logic h, output logic [15:0] d);
    @(negedge clk);
    hsel = h;
    @(negedge clk);
    {cs_n, rc_n} = 2'b01;
    repeat (2) @(negedge clk);
    d = bus;
    cs_n = 1'b1;
  endtask : read
endmodule : sadc_host_model

/* File: test/sar_adc_parallel_host_port_tb.sv */
// Purpose: converter port bench
// Assumes: CONV_CYCLES of 4
// Notes: fifo fed here
`timescale 1ns/1ps
module sar_adc_parallel_host_port_tb;
  logic clk = 1'b0, arst_n = 1'b0, sv = 1'b0, sr, bn, cs_n, rc_n, hs;
  logic [15:0] sd = 16'h0000, bo, boe, d;
  wire [15:0] rb;
  int bad_count = 0, check_count = 0, cyc = 0;
  always #4 clk = ~clk;
  for (genvar i = 0; i < 16; i++) begin : g_pin
    assign rb[i] = boe[i] ? bo[i] : 1'bz;
  end
  sadc_host_model host (.clk(clk), .bus(rb), .cs_n(cs_n), .rc_n(rc_n), .hsel(hs));
  sadc_port #(.CONV_CYCLES(4)) DUT (.clk(clk), .arst_n(arst_n), .chip_select_n(cs_n),
    .read_convert_n(rc_n), .half_select(hs), .sample_valid(sv), .sample_ready(sr),
    .sample_data(sd), .busy_n(bn), .result_bus_o(bo), .result_bus_oe(boe));
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      conclude();
    end
  end
  task automatic push(input logic [15:0] v);
    @(negedge clk);
    {sv, sd} = {1'b1, v};
    @(negedge clk);
    sv = 1'b0;
  endtask : push
  // wait out busy, read both halves
  task automatic fetch(input logic [15:0] v);
    for (int n = 0; n < 40 && bn !== 1'b1; n++) @(negedge clk);
    chk("busy", 16'h0001, {15'h0000, bn});
    host.read(1'b0, d);
    chk("upper", {v[15:8], v[15:8]}, d);
    host.read(1'b1, d);
    chk("lower", v, d);
  endtask : fetch
  // fill to full, drain one per conversion
  task automatic t_stream();
    for (int i = 0; i < 8; i++) push(16'h8000 ^ (16'h0f0f << i));
    chk("ready", 16'h0000, {15'h0000, sr});
    for (int i = 0; i < 8; i++) begin
      host.convert(1'b0);
      fetch(16'h8000 ^ (16'h0f0f << i));
    end
    $display("stream end");
  endtask : t_stream
  // no sample: busy waits
  task automatic t_empty();
    host.convert(1'b0);
    repeat (4) @(negedge clk);
    chk("busy", 16'h0000, {15'h0000, bn});
    push(16'ha5c3);
    fetch(16'ha5c3);
    $display("empty end");
  endtask : t_empty
  // convert while busy restarts
  task automatic t_cut();
    push(16'h3c5a);
    host.convert(1'b1);
    repeat (2) @(negedge clk);
    chk("busy", 16'h0000, {15'h0000, bn});
    chk("bus", 16'hzzzz, rb);
    fetch(16'h3c5a);
    push(16'h5a3c);
    host.convert(1'b0);
    fetch(16'h5a3c);
    $display("cut end");
  endtask : t_cut
  initial begin
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    t_stream();
    t_empty();
    t_cut();
    conclude();
  end
endmodule : sar_adc_parallel_host_port_tb
